// *** shared/dcss_pkg.sv ***
// Package of constants, register map and types for the command source select
`default_nettype none
package dcss_pkg;
  // ==========================================================
  // Register byte offsets (Wishbone, 32-bit words)
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_FMAX     = 8'h04;
  localparam logic [7:0] ADDR_FMIN     = 8'h08;
  localparam logic [7:0] ADDR_RAMP_T   = 8'h0c;
  localparam logic [7:0] ADDR_RAMP_REF = 8'h10;
  localparam logic [7:0] ADDR_VBIAS    = 8'h14;
  localparam logic [7:0] ADDR_VGAIN    = 8'h18;
  localparam logic [7:0] ADDR_IBIAS    = 8'h1c;
  localparam logic [7:0] ADDR_IGAIN    = 8'h20;
  localparam logic [7:0] ADDR_RATED_F  = 8'h24;
  localparam logic [7:0] ADDR_RATED_V  = 8'h28;
  localparam logic [7:0] ADDR_FM_CAL   = 8'h2c;
  localparam logic [7:0] ADDR_PANEL    = 8'h30;
  localparam logic [7:0] ADDR_STATUS   = 8'h34;
  localparam logic [7:0] ADDR_FOUT     = 8'h38;
  // ==========================================================
  // CTRL field positions
  localparam int CTRL_MODE_LSB  = 0;  // 2-bit requested mode
  localparam int CTRL_PWRON_PU  = 2;  // Panel mode at power-on
  localparam int CTRL_VRANGE    = 3;  // 1 = 0..5 V range
  // PANEL field positions
  localparam int PANEL_FWD      = 0;
  localparam int PANEL_REV      = 1;
  localparam int PANEL_FREQ_LSB = 16; // 16-bit frequency setpoint
  // ==========================================================
  // Frequencies in units of 0.01 Hz, ADC codes 12-bit
  localparam logic [15:0] FREQ_60HZ   = 16'h1770;
  localparam logic [15:0] FREQ_0HZ    = 16'h0000;
  localparam logic [11:0] ADC_FULL    = 12'hfff;  // 10 V or 20 mA
  localparam logic [11:0] ADC_HALF    = 12'h7ff;  // 5 V on 10 V scale
  localparam logic [11:0] ADC_4MA     = 12'h333;  // 4 mA of 20 mA
  localparam logic [11:0] ADC_ZERO    = 12'h000;
  localparam logic [15:0] RAMP_T_RST  = 16'h0096;  // 15.0 s in 0.1 s
  localparam logic [15:0] RATED_F_RST = 16'h1770;
  localparam logic [15:0] RATED_V_RST = 16'h0000;
  localparam logic [15:0] FM_CAL_RST  = 16'h1000;  // Unity gain, 4.12
  // ==========================================================
  // Timing
  localparam int CLK_HZ          = 200_000_000;
  localparam int RAMP_UNIT_MS    = 100;  // Ramp time unit 0.1 s
  localparam int RAMP_UNIT_CYC   = CLK_HZ / 1000 * RAMP_UNIT_MS;
  // ==========================================================
  typedef enum logic [1:0] {
    DCSS_MODE_EXT,      // Terminals for start and frequency
    DCSS_MODE_PANEL,    // Panel for everything
    DCSS_MODE_EXT_RUN,  // Terminals start, panel frequency
    DCSS_MODE_EXT_FREQ  // Panel start, terminal frequency
  } dcss_mode_e;
  typedef struct packed {
    logic fwd;
    logic rev;
  } dcss_run_s;
endpackage
`default_nettype wire

// *** rtl/dcss_top.sv ***
// Command source selection, analog scaling, clamp and ramp of the drive
//
// Decided for this implementation: the Wishbone slave port and the address map.
`default_nettype none
module dcss_top #(
  parameter int RAMP_UNIT_CYCLES = dcss_pkg::RAMP_UNIT_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Control terminals (asynchronous pins)
  input  wire logic        forward_run_input_i,
  input  wire logic        reverse_run_input_i,
  input  wire logic        current_input_select_i,
  // Analog reference samples from converters, same clock
  input  wire logic [11:0] volt_ref_i,
  input  wire logic [11:0] curr_ref_i,
  // Drive outputs
  output logic      [15:0] freq_out_o,
  output logic             run_fwd_o,
  output logic             run_rev_o,
  output logic      [15:0] freq_meter_o,
  output logic      [1:0]  mode_o
);

  // ==========================================================
  // Registers
  dcss_pkg::dcss_mode_e mode;
  logic        pwron_panel = 1'b0; // Survives rst_i
  logic        vrange5;
  logic [15:0] fmax, fmin, ramp_t, ramp_ref;
  logic [11:0] vbias, vgain, ibias, igain;
  logic [15:0] rated_f, rated_v, fm_cal;
  dcss_pkg::dcss_run_s panel_run;
  logic [15:0] panel_freq;
  logic        mode_refused;
  logic        pwron_done;

  // ==========================================================
  // Pin synchronisers: three stages, change accepted when 2 and 3 agree
  logic [2:0] fwd_sy, rev_sy, au_sy;
  logic       fwd_pin, rev_pin, au_pin;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fwd_sy <= 3'h0;
      rev_sy <= 3'h0;
      au_sy  <= 3'h0;
    end else begin
      fwd_sy <= {fwd_sy[1:0], forward_run_input_i};
      rev_sy <= {rev_sy[1:0], reverse_run_input_i};
      au_sy  <= {au_sy[1:0], current_input_select_i};
    end
  end

  // Debounced levels; a disagreement keeps the last value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fwd_pin <= 1'b0;
      rev_pin <= 1'b0;
      au_pin  <= 1'b0;
    end else begin
      if (fwd_sy[1] == fwd_sy[2]) fwd_pin <= fwd_sy[2];
      if (rev_sy[1] == rev_sy[2]) rev_pin <= rev_sy[2];
      if (au_sy[1] == au_sy[2])   au_pin  <= au_sy[2];
    end
  end

  // ==========================================================
  // Command source selection
  logic start_ext, freq_ext;
  logic cmd_fwd, cmd_rev;
  logic any_run;
  always_comb begin
    start_ext = 1'b1;
    freq_ext  = 1'b1;
    unique case (mode)
      dcss_pkg::DCSS_MODE_EXT: begin
        start_ext = 1'b1;
        freq_ext  = 1'b1;
      end
      dcss_pkg::DCSS_MODE_PANEL: begin
        start_ext = 1'b0;
        freq_ext  = 1'b0;
      end
      dcss_pkg::DCSS_MODE_EXT_RUN: begin
        start_ext = 1'b1;
        freq_ext  = 1'b0;
      end
      dcss_pkg::DCSS_MODE_EXT_FREQ: begin
        start_ext = 1'b0;
        freq_ext  = 1'b1;
      end
    endcase
    cmd_fwd = start_ext ? fwd_pin : panel_run.fwd;
    cmd_rev = start_ext ? rev_pin : panel_run.rev;
    // Any run request from either source blocks a mode change
    any_run = fwd_pin | rev_pin | panel_run.fwd | panel_run.rev;
  end

  // ==========================================================
  // Analog scaling: linear between bias (0 Hz) and gain (60 Hz) points
  logic        use_curr;
  logic [11:0] a_in, a_bias, a_gain;
  logic [12:0] span, num;
  logic [28:0] prod;
  logic [15:0] analog_freq;
  always_comb begin
    use_curr = au_pin;
    a_in   = use_curr ? curr_ref_i : volt_ref_i;
    a_bias = use_curr ? ibias : vbias;
    a_gain = use_curr ? igain : vgain;
    if (!use_curr && vrange5 && vgain == dcss_pkg::ADC_FULL) begin
      a_gain = dcss_pkg::ADC_HALF;
    end
    // A gain point equal to the bias point collapses the span; the
    // output then stays at 0 Hz, while a gain point below it wraps the span
    span = {1'b0, a_gain} - {1'b0, a_bias};
    num  = (a_in > a_bias) ? ({1'b0, a_in} - {1'b0, a_bias}) : 13'h0000;
    if (num > span) num = span;
    // Above the gain point the reference saturates at the 60 Hz point
    prod = 29'(num) * 29'(dcss_pkg::FREQ_60HZ);
    if (span == 13'h0000) begin
      analog_freq = dcss_pkg::FREQ_0HZ;
    end else begin
      analog_freq = 16'(prod / 29'(span));
    end
  end

  // ==========================================================
  // Target frequency, clamp and direction decision
  logic [15:0] ref_freq, target;
  logic        both_dir, run_req;
  always_comb begin
    ref_freq = freq_ext ? analog_freq : panel_freq;
    both_dir = cmd_fwd & cmd_rev;
    run_req  = (cmd_fwd | cmd_rev) & ~both_dir;
    target   = ref_freq;
    if (target > fmax) target = fmax;
    if (target < fmin) target = fmin;
    if (!run_req) target = dcss_pkg::FREQ_0HZ;
  end

  // ==========================================================
  // Ramp generator: step sized so ramp_ref is reached in ramp_t units.
  // The step is rounded down, so a ramp can take a little longer than
  // the programmed time; it never overshoots the target
  logic [31:0] tick_cnt;
  logic        tick;
  logic [15:0] step;
  always_comb begin
    tick = (tick_cnt == 32'(RAMP_UNIT_CYCLES - 1));
    step = (ramp_t == 16'h0000) ? ramp_ref : ramp_ref / ramp_t;
    if (step == 16'h0000) step = 16'h0001;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) tick_cnt <= 32'h0;
    else if (tick) tick_cnt <= 32'h0;
    else tick_cnt <= tick_cnt + 32'h1;
  end

  // Output frequency walks toward target; direction holds until stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      freq_out_o <= 16'h0000;
      run_fwd_o  <= 1'b0;
      run_rev_o  <= 1'b0;
    end else begin
      if (freq_out_o == 16'h0000) begin
        // Starting needs one clean direction; both held means no start
        run_fwd_o <= run_req & cmd_fwd;
        run_rev_o <= run_req & cmd_rev;
      end
      if (tick) begin
        if (freq_out_o < target) begin
          freq_out_o <= (target - freq_out_o > step) ?
                        freq_out_o + step : target;
        end else if (freq_out_o > target) begin
          freq_out_o <= (freq_out_o - target > step) ?
                        freq_out_o - step : target;
        end
      end
    end
  end

  // Frequency meter: calibrated gain replaces the trim resistor
  logic [31:0] fm_prod;
  always_comb fm_prod = freq_out_o * fm_cal;
  always_ff @(posedge clk_i) begin
    if (rst_i) freq_meter_o <= 16'h0000;
    else freq_meter_o <= fm_prod[27:12];
  end

  // ==========================================================
  // Wishbone slave; single-cycle ack, one idle cycle after each ack.
  // Writes land at the edge where the master sees ack, so a request that
  // is withdrawn before its answer never changes a setting
  logic wb_req, wb_wr;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) wb_ack_o <= 1'b0;
    else wb_ack_o <= wb_req;
  end

  // Mode: reset to external, then power-on preference applied once.
  // A refused change leaves the mode alone and raises a sticky flag that
  // only a write to the status word or rst_i clears
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode         <= dcss_pkg::DCSS_MODE_EXT;
      pwron_done   <= 1'b0;
      mode_refused <= 1'b0;
    end else begin
      pwron_done <= 1'b1;
      if (!pwron_done && pwron_panel) begin
        mode <= dcss_pkg::DCSS_MODE_PANEL;
      end
      if (wb_wr && wb_adr_i == dcss_pkg::ADDR_CTRL && wb_sel_i[0]) begin
        if (any_run) mode_refused <= 1'b1;
        else mode <= dcss_pkg::dcss_mode_e'(wb_dat_i[1:0]);
      end else if (wb_wr && wb_adr_i == dcss_pkg::ADDR_STATUS) begin
        mode_refused <= 1'b0;
      end
    end
  end

  // Settings; all return to their factory values on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vrange5     <= 1'b0;
      fmax        <= dcss_pkg::FREQ_60HZ;
      fmin        <= dcss_pkg::FREQ_0HZ;
      ramp_t      <= dcss_pkg::RAMP_T_RST;
      ramp_ref    <= dcss_pkg::FREQ_60HZ;
      vbias       <= dcss_pkg::ADC_ZERO;
      vgain       <= dcss_pkg::ADC_FULL;
      ibias       <= dcss_pkg::ADC_4MA;
      igain       <= dcss_pkg::ADC_FULL;
      rated_f     <= dcss_pkg::RATED_F_RST;
      rated_v     <= dcss_pkg::RATED_V_RST;
      fm_cal      <= dcss_pkg::FM_CAL_RST;
      panel_run   <= '0;
      panel_freq  <= dcss_pkg::FREQ_0HZ;
    end else if (wb_wr) begin
      unique case (wb_adr_i)
        dcss_pkg::ADDR_CTRL: begin
          vrange5     <= wb_dat_i[dcss_pkg::CTRL_VRANGE];
        end
        dcss_pkg::ADDR_FMAX:     fmax     <= wb_dat_i[15:0];
        dcss_pkg::ADDR_FMIN:     fmin     <= wb_dat_i[15:0];
        dcss_pkg::ADDR_RAMP_T:   ramp_t   <= wb_dat_i[15:0];
        dcss_pkg::ADDR_RAMP_REF: ramp_ref <= wb_dat_i[15:0];
        dcss_pkg::ADDR_VBIAS:    vbias    <= wb_dat_i[11:0];
        dcss_pkg::ADDR_VGAIN:    vgain    <= wb_dat_i[11:0];
        dcss_pkg::ADDR_IBIAS:    ibias    <= wb_dat_i[11:0];
        dcss_pkg::ADDR_IGAIN:    igain    <= wb_dat_i[11:0];
        dcss_pkg::ADDR_RATED_F:  rated_f  <= wb_dat_i[15:0];
        dcss_pkg::ADDR_RATED_V:  rated_v  <= wb_dat_i[15:0];
        dcss_pkg::ADDR_FM_CAL:   fm_cal   <= wb_dat_i[15:0];
        dcss_pkg::ADDR_PANEL: begin
          panel_run.fwd <= wb_dat_i[dcss_pkg::PANEL_FWD];
          panel_run.rev <= wb_dat_i[dcss_pkg::PANEL_REV];
          panel_freq    <= wb_dat_i[31:16];
        end
        default: ;
      endcase
    end
  end

  // Power-on preference stays out of rst_i so that it outlives a reset and
  // picks panel mode on the way out of the next one
  always_ff @(posedge clk_i) begin
    if (wb_wr && wb_adr_i == dcss_pkg::ADDR_CTRL) begin
      pwron_panel <= wb_dat_i[dcss_pkg::CTRL_PWRON_PU];
    end
  end

  // Read mux registered with the ack; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (wb_req && !wb_we_i) begin
      unique case (wb_adr_i)
        dcss_pkg::ADDR_CTRL:
          wb_dat_o <= {28'h0, vrange5, pwron_panel, mode};
        dcss_pkg::ADDR_FMAX:     wb_dat_o <= {16'h0, fmax};
        dcss_pkg::ADDR_FMIN:     wb_dat_o <= {16'h0, fmin};
        dcss_pkg::ADDR_RAMP_T:   wb_dat_o <= {16'h0, ramp_t};
        dcss_pkg::ADDR_RAMP_REF: wb_dat_o <= {16'h0, ramp_ref};
        dcss_pkg::ADDR_VBIAS:    wb_dat_o <= {20'h0, vbias};
        dcss_pkg::ADDR_VGAIN:    wb_dat_o <= {20'h0, vgain};
        dcss_pkg::ADDR_IBIAS:    wb_dat_o <= {20'h0, ibias};
        dcss_pkg::ADDR_IGAIN:    wb_dat_o <= {20'h0, igain};
        dcss_pkg::ADDR_RATED_F:  wb_dat_o <= {16'h0, rated_f};
        dcss_pkg::ADDR_RATED_V:  wb_dat_o <= {16'h0, rated_v};
        dcss_pkg::ADDR_FM_CAL:   wb_dat_o <= {16'h0, fm_cal};
        dcss_pkg::ADDR_PANEL:
          wb_dat_o <= {panel_freq, 14'h0, panel_run.rev, panel_run.fwd};
        dcss_pkg::ADDR_STATUS:
          wb_dat_o <= {25'h0, mode_refused, au_pin, both_dir,
                       run_rev_o, run_fwd_o, rev_pin, fwd_pin};
        dcss_pkg::ADDR_FOUT:     wb_dat_o <= {16'h0, freq_out_o};
        default:                 wb_dat_o <= 32'h0;
      endcase
    end
  end

  // Current mode exported for a panel indicator
  always_ff @(posedge clk_i) begin
    if (rst_i) mode_o <= 2'h0;
    else mode_o <= mode;
  end

endmodule
`default_nettype wire

// *** dv/dcss_monitor.sv ***
// Bound checker of the command source select ports
`default_nettype none
module dcss_monitor #(
  parameter int RAMP_UNIT_CYCLES = 4
) (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Terminals and converters
  input wire logic        forward_run_input_i,
  input wire logic        reverse_run_input_i,
  input wire logic        current_input_select_i,
  input wire logic [11:0] volt_ref_i,
  input wire logic [11:0] curr_ref_i,
  // Drive outputs
  input wire logic [15:0] freq_out_o,
  input wire logic        run_fwd_o,
  input wire logic        run_rev_o,
  input wire logic [15:0] freq_meter_o,
  input wire logic [1:0]  mode_o
);
  // ==========================================================
  // Properties; stable-for-three assumes a ramp unit of 4 or more
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o) else $error("bus request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  reset_state_a: assert property (disable iff (1'b0) rst_i |=>
    mode_o == 2'h0 && !wb_ack_o && freq_out_o == 16'h0)
    else $error("outputs not cleared by reset");
  mode_by_bus_a: assert property ($changed(mode_o) |->
    $past(wb_ack_o, 2) || $past(rst_i, 3))
    else $error("mode moved without bus or reset");
  dir_excl_a: assert property (!(run_fwd_o && run_rev_o))
    else $error("both directions running");
  dir_latch_a: assert property ($changed({run_fwd_o, run_rev_o}) |->
    $past(freq_out_o) == 16'h0) else $error("direction moved at speed");
  ramp_step_a: assert property ($changed(freq_out_o) |=>
    $stable(freq_out_o) [*3]) else $error("ramp steps too fast");
  read_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved without ack");
  // Main scenarios reached
  cover property (wb_ack_o && wb_we_i);
  cover property ($rose(run_fwd_o));
  cover property (mode_o == 2'h3 && freq_out_o != 16'h0);
  cover property ($changed(mode_o) && $past(rst_i, 3));
endmodule
bind dcss_top dcss_monitor #(.RAMP_UNIT_CYCLES(RAMP_UNIT_CYCLES)) mon (
  .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .wb_dat_o, .wb_ack_o, .forward_run_input_i,
  .reverse_run_input_i, .current_input_select_i, .volt_ref_i, .curr_ref_i,
  .freq_out_o, .run_fwd_o, .run_rev_o, .freq_meter_o, .mode_o);
`default_nettype wire

// *** dv/dcss_terminal_model.sv ***
// Model of the control terminals and analog converters
`default_nettype none
module dcss_terminal_model (
  // Clock
  input  wire logic        clk_i,
  // Wanted contact and analog states
  input  wire logic        fwd_i,
  input  wire logic        rev_i,
  input  wire logic        au_i,
  input  wire logic [11:0] volt_i,
  input  wire logic [11:0] curr_i,
  // Pins and converter samples
  output logic             fwd_pin_o,
  output logic             rev_pin_o,
  output logic             au_pin_o,
  output logic [11:0]      volt_o,
  output logic [11:0]      curr_o
);
  // Contacts close to common after the edge; loop reads garbage unselected
  always_ff @(posedge clk_i) begin
    fwd_pin_o <= fwd_i;
    rev_pin_o <= rev_i;
    au_pin_o  <= au_i;
    volt_o    <= volt_i;
    curr_o    <= au_i ? curr_i : ~curr_i;
  end
endmodule
`default_nettype wire

// *** dv/tb_dcss_top.sv ***
// Self-checking bench of the command source select block
`default_nettype none
module tb_dcss_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] mask;
  } dcss_note_s;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic        rd_on = 1'b0;
  logic        peek = 1'b0;
  logic [31:0] got;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic        fwd = 1'b0;
  logic        rev = 1'b0;
  logic        au = 1'b0;
  logic [11:0] volt = 12'h000;
  logic [11:0] curr = 12'h000;
  wire logic   fp, rp, ap, ack, rf, rr;
  wire logic [11:0] vs, cs;
  wire logic [31:0] rdat;
  wire logic [15:0] fout, fm;
  wire logic [1:0]  mode;
  int          fails = 0;
  int          num_checks = 0;
  int          seed = 32'hb32261a4;
  dcss_note_s  notes[$];
  dcss_note_s  note;
  logic [31:0] rst_val[13] = '{32'h0, 32'h1770, 32'h0, 32'h96, 32'h1770,
    32'h0, 32'hfff, 32'h333, 32'hfff, 32'h1770, 32'h0, 32'h1000, 32'h0};
  localparam logic [7:0] FOUT = dcss_pkg::ADDR_FOUT;
  localparam logic [7:0] CTRL = dcss_pkg::ADDR_CTRL;
  localparam logic [7:0] PANEL = dcss_pkg::ADDR_PANEL;
  // Clock of 5 ns
  always #2.5 clk_i = ~clk_i;
  dcss_terminal_model term (.clk_i, .fwd_i(fwd), .rev_i(rev), .au_i(au),
    .volt_i(volt), .curr_i(curr), .fwd_pin_o(fp), .rev_pin_o(rp),
    .au_pin_o(ap), .volt_o(vs), .curr_o(cs));
  dcss_top #(.RAMP_UNIT_CYCLES(4)) uut (.clk_i, .rst_i, .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .forward_run_input_i(fp), .reverse_run_input_i(rp),
    .current_input_select_i(ap), .volt_ref_i(vs), .curr_ref_i(cs),
    .freq_out_o(fout), .run_fwd_o(rf), .run_rev_o(rr),
    .freq_meter_o(fm), .mode_o(mode));
  task automatic print_verdict();
    if (notes.size() != 0) begin
      fails++;
      $display("unexpected %0t %0d results never seen", $time, notes.size());
    end
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One classic cycle; held until ack is sampled, then released
  task automatic wb_cycle(input logic w, input logic [3:0] s,
                          input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    rd_on <= !w;
    sel <= s;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    cyc <= 1'b0;
    if (n >= 40) begin
      fails++;
      $display("unexpected %0t bus timeout", $time);
      print_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_cycle(1'b1, 4'hf, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    notes.push_back('{exp: e, mask: m});
    wb_cycle(1'b0, 4'hf, a, 32'h0);
  endtask
  // Snapshot of the drive outputs: {meter, 12'h0, rev, fwd, mode}
  task automatic look(input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{exp: e, mask: m});
    @(posedge clk_i);
    peek <= 1'b1;
    @(posedge clk_i);
    peek <= 1'b0;
  endtask
  // Long enough for a full ramp of 150 steps of 4 cycles
  task automatic settle();
    repeat (800) @(posedge clk_i);
  endtask
  // Oldest note is matched against each answered read
  always @(posedge clk_i) begin
    if (((ack === 1'b1 && rd_on) || peek === 1'b1) && notes.size() > 0) begin
      note = notes.pop_front();
      num_checks++;
      got = (peek === 1'b1) ? {fm, 12'h000, rr, rf, mode} : rdat;
      if ((got & note.mask) !== (note.exp & note.mask)) begin
        fails++;
        $display("unexpected %0t read %h not %h", $time, got, note.exp);
      end
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 13; i++)
      rd(8'(i * 4), rst_val[i], '1);
    rd(8'h3c, 32'h0, '1);
    volt <= 12'hfff;
    fwd <= 1'b1;
    settle();
    rd(FOUT, 32'h1770, 32'hffff);
    wr(CTRL, 32'h1);
    rd(CTRL, 32'h0, 32'h3);
    rd(dcss_pkg::ADDR_STATUS, 32'h45, 32'h7f);
    rev <= 1'b1;
    settle();
    rd(FOUT, 32'h0, 32'hffff);
    fwd <= 1'b0;
    rev <= 1'b0;
    repeat (10) @(posedge clk_i);  // Pins pass the filter first
    wr(dcss_pkg::ADDR_STATUS, 32'h0);
    wb_cycle(1'b1, 4'he, CTRL, 32'h1);
    rd(CTRL, 32'h0, 32'h3);
    wr(CTRL, 32'h1);
    wr(PANEL, 32'h2000_0001);
    volt <= 12'($random(seed));
    fwd <= 1'b1;
    settle();
    rd(FOUT, 32'h1770, 32'hffff);
    wr(dcss_pkg::ADDR_FMAX, 32'h1000);
    settle();
    rd(FOUT, 32'h1000, 32'hffff);
    wr(PANEL, 32'h2000_0000);
    settle();
    rd(FOUT, 32'h0, 32'hffff);
    fwd <= 1'b0;
    repeat (10) @(posedge clk_i);  // Run request gone before mode write
    wr(dcss_pkg::ADDR_FMAX, 32'h1770);
    wr(CTRL, 32'h2);
    wr(PANEL, 32'h0bb8_0002);
    volt <= 12'($random(seed));
    fwd <= 1'b1;
    settle();
    rd(FOUT, 32'h0bb8, 32'hffff);
    rd(dcss_pkg::ADDR_STATUS, 32'h5, 32'hd);
    wr(dcss_pkg::ADDR_FM_CAL, 32'h0800);
    look(32'h05dc_0006, 32'hffff_000f);
    fwd <= 1'b0;
    wr(PANEL, 32'h0);
    settle();
    wr(CTRL, 32'h3);
    volt <= 12'hfff;
    fwd <= 1'b1;
    settle();
    rd(FOUT, 32'h0, 32'hffff);
    wr(PANEL, 32'h0000_0001);
    settle();
    rd(FOUT, 32'h1770, 32'hffff);
    fwd <= 1'b0;
    wr(PANEL, 32'h0);
    settle();
    wr(CTRL, 32'h0);
    au <= 1'b1;
    curr <= 12'h333;
    volt <= 12'($random(seed));
    fwd <= 1'b1;
    settle();
    rd(FOUT, 32'h0, 32'hffff);
    curr <= 12'hfff;
    settle();
    rd(FOUT, 32'h1770, 32'hffff);
    au <= 1'b0;
    volt <= 12'hfff;
    settle();
    rd(FOUT, 32'h1770, 32'hffff);
    fwd <= 1'b0;
    settle();
    wr(CTRL, 32'h8);
    volt <= 12'h7ff;
    fwd <= 1'b1;
    settle();
    rd(FOUT, 32'h1770, 32'hffff);
    volt <= 12'h000;
    wr(dcss_pkg::ADDR_FMIN, 32'h0100);
    settle();
    rd(FOUT, 32'h0100, 32'hffff);
    fwd <= 1'b0;
    settle();
    wr(CTRL, 32'h4);
    rd(CTRL, 32'h4, 32'hf);
    // Reset with the drive stopped: the power-on preference must pick panel mode
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    look(32'h0000_0001, 32'hffff_000f);
    rd(CTRL, 32'h5, 32'hf);
    repeat (2) @(posedge clk_i);
    print_verdict();
  end
endmodule
`default_nettype wire
